// ### mbf_array.sv
/*
 * Small word array standing in for the flash cells; registered read data.
 * Assumes: write and read addresses are already cut to AW bits.
 */
`timescale 1ns/10ps
module mbf_array #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    initial begin
        if (AW < 1 || AW > 16) $error("mbf_array: AW out of range");
    end

    // Cells hold no reset; only the read register does
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data always from a register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : mbf_array

// ### mbf_ctrl.sv
/*
 * Pin control of a multiplexed address/data burst flash: address latch,
 * burst counting, ready, hardware reset, write protect and supply lockout.
 * Assumes: every pin is asynchronous to clk_sys and held long enough to be
 * seen through three flip-flops; the bus wire is resolved outside.
 */
`timescale 1ns/10ps

// Function
// - A rising burst clock with the strobe low latches the address and starts a burst.
// - After the first burst word, each rising burst clock advances the address by one word.
// - In asynchronous mode the address is taken as valid while the strobe is low.
// - With the strobe high no address is taken from the pins.
// - Low sixteen address bits share the data pins; the upper bits have their own pins.
// - Hardware reset low returns the block to array read.
// - Write protect low refuses program of the four top sectors.
// - Supply at high voltage speeds programming and enters unlock bypass.
// - Supply at logic low refuses every program.
// - Test pins low keep their functions inactive.
// - Chip select and output enable are sampled as asynchronous inputs.
// - Ready goes high while valid burst data is on the bus.
// - Bursts run continuously, or wrap within aligned groups of 8, 16 or 32 words when wrap is on.
module mbf_ctrl #(
    parameter int MEM_AW = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Host strobes and burst clock
    input wire logic burst_clk,
    input wire logic address_valid_strobe_n,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    // Reset, protection and supply level
    input wire logic hw_reset_n,
    input wire logic write_protect_n,
    input wire logic vpp_above_logic_low_level,
    input wire logic vpp_at_high_voltage_level,
    input wire logic vendor_test_pin,
    // Address and muxed bus
    input wire logic [mbf_pkg::UP_W-1:0] addr_upper,
    input wire logic [mbf_pkg::DATA_W-1:0] muxed_addr_data_bus_in,
    output logic [mbf_pkg::DATA_W-1:0] muxed_addr_data_bus_out,
    output logic muxed_addr_data_bus_oe,
    output logic ready,
    // Burst configuration and status
    input wire mbf_pkg::mbf_cfg_t cfg,
    output mbf_pkg::mbf_status_t status
);
    import mbf_pkg::*;

    initial begin
        if (MEM_AW < 1 || MEM_AW > ADDR_W) $error("mbf_ctrl: MEM_AW out of range");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Next burst address: group wrap keeps the upper bits fixed
    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a, input mbf_cfg_t c);
        logic [ADDR_W-1:0] mask;
        logic [ADDR_W-1:0] inc;
        mask = '0;
        inc = a + 25'h0000001;
        case (c.blen)
            MBF_LEN_8: mask = 25'h0000007;
            MBF_LEN_16: mask = 25'h000000F;
            MBF_LEN_32: mask = 25'h000001F;
            default: mask = '0;
        endcase
        // Continuous length has no group, so wrap has nothing to act on
        if (c.wrap_en && c.blen != MBF_LEN_CONT) begin
            next_addr = (a & ~mask) | (inc & mask);
        end else begin
            next_addr = inc;
        end
    endfunction : next_addr

    // Top four sectors of the array
    function automatic logic in_top(input logic [ADDR_W-1:0] a);
        in_top = a[ADDR_W-1:SECT_LSB] >= TOP_SECT_MIN;
    endfunction : in_top

    // ****************************************************************
    // State
    // ****************************************************************
    mbf_state_t st_r;
    mbf_state_t st_nxt;
    mbf_pins_t pins;
    logic [DATA_W-1:0] rd_data;
    mbf_pins_t stb_nxt;
    logic bclk_rise;
    logic we_rise;
    logic hrst;
    logic prog_try;
    logic prog_bad;
    logic wr_en;
    logic [ADDR_W-1:0] adv_addr;
    logic [ADDR_W-1:0] pin_addr;

    // Pins gathered into one word
    always_comb begin
        pins.bclk = burst_clk;
        pins.avd_n = address_valid_strobe_n;
        pins.ce_n = chip_sel_n;
        pins.oe_n = out_en_n;
        pins.we_n = write_en_n;
        pins.hrst_n = hw_reset_n;
        pins.wp_n = write_protect_n;
        pins.vpp_ih = vpp_above_logic_low_level;
        pins.vpp_hh = vpp_at_high_voltage_level;
        pins.tst = vendor_test_pin;
        pins.up = addr_upper;
        pins.bus = muxed_addr_data_bus_in;
    end

    // A change counts once the last two stages agree; kept apart from st_nxt so no loop forms
    assign stb_nxt = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) | (st_r.stb & (st_r.s2 ^ st_r.s3));

    // Edges seen on the filtered copies only
    assign bclk_rise = stb_nxt.bclk & ~st_r.stb.bclk;
    assign we_rise = stb_nxt.we_n & ~st_r.stb.we_n;
    assign hrst = ~st_r.stb.hrst_n;
    assign pin_addr = {st_r.stb.up, st_r.stb.bus};
    assign adv_addr = next_addr(st_r.addr, cfg);
    assign prog_try = we_rise & ~st_r.stb.ce_n & st_r.stb.avd_n & ~hrst;
    assign prog_bad = ~st_r.stb.vpp_ih | (~st_r.stb.wp_n & in_top(st_r.addr));
    assign wr_en = prog_try & ~prog_bad;

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Synchroniser, address latch, burst counter and program gate
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.stb = stb_nxt;
        st_nxt.stat.prog_done = 1'b0;
        st_nxt.stat.prog_refused = 1'b0;
        st_nxt.stat.prog_fast = 1'b0;
        if (hrst) begin
            // Drop burst and address, back to array read
            st_nxt.mode = MBF_IDLE;
            st_nxt.addr = ADDR_RST;
            st_nxt.first = 1'b0;
        end else if (!st_r.stb.avd_n && !st_r.stb.ce_n) begin
            if (bclk_rise) begin
                st_nxt.mode = MBF_BURST;
                st_nxt.addr = pin_addr;
                st_nxt.first = 1'b0;
            end else if (!st_r.stb.bclk) begin
                // A fresh async address also ends any earlier burst
                st_nxt.mode = MBF_ASYNC;
                st_nxt.addr = pin_addr;
            end
        end else if (st_r.mode == MBF_BURST && bclk_rise) begin
            // Strobe high: pins ignored, only the counter moves
            if (st_r.first) begin
                st_nxt.addr = adv_addr;
            end else begin
                st_nxt.first = 1'b1;
            end
        end
        // Program attempt on the write strobe rising edge
        if (prog_try) begin
            st_nxt.stat.prog_done = ~prog_bad;
            st_nxt.stat.prog_refused = prog_bad;
            st_nxt.stat.prog_fast = ~prog_bad & st_r.stb.vpp_hh;
        end
        st_nxt.stat.unlock_bypass = st_r.stb.vpp_hh;
        st_nxt.stat.test_active = st_r.stb.tst;
        st_nxt.ready = (st_nxt.mode == MBF_BURST) & st_nxt.first & ~st_nxt.stb.ce_n;
        st_nxt.drive = ~st_nxt.stb.ce_n & ~st_nxt.stb.oe_n & st_nxt.stb.avd_n
                       & st_nxt.stb.we_n & (st_nxt.mode != MBF_IDLE);
    end

    // The whole state in one register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Array and outputs
    // ****************************************************************

    // Read address follows the next address so data lines up with it
    mbf_array #(
        .AW(MEM_AW),
        .DW(DATA_W)
    ) u_array (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr_en(wr_en),
        .wr_addr(st_r.addr[MEM_AW-1:0]),
        .wr_data(st_r.stb.bus),
        .rd_addr(st_nxt.addr[MEM_AW-1:0]),
        .rd_data(rd_data)
    );

    // Outputs straight from registers
    assign muxed_addr_data_bus_out = rd_data;
    assign muxed_addr_data_bus_oe = st_r.drive;
    assign ready = st_r.ready;
    assign status = st_r.stat;

    // ****************************************************************
    // Checks
    // ****************************************************************

    property p_burst_latch;
        @(posedge clk_sys) disable iff (!rst_b)
        (bclk_rise && !st_r.stb.avd_n && !st_r.stb.ce_n && !hrst)
            |=> (st_r.mode == MBF_BURST) && (st_r.addr == $past(pin_addr)) && !st_r.first;
    endproperty
    a_burst_latch: assert property (p_burst_latch) else $error("burst address not latched");

    property p_burst_adv;
        @(posedge clk_sys) disable iff (!rst_b)
        (st_r.mode == MBF_BURST && st_r.first && bclk_rise && st_r.stb.avd_n && !hrst)
            |=> st_r.addr == $past(adv_addr);
    endproperty
    a_burst_adv: assert property (p_burst_adv) else $error("burst address did not advance");

    property p_async_latch;
        @(posedge clk_sys) disable iff (!rst_b)
        (!st_r.stb.avd_n && !st_r.stb.ce_n && !st_r.stb.bclk && !bclk_rise
         && !hrst)
            |=> st_r.mode == MBF_ASYNC && st_r.addr == $past(pin_addr);
    endproperty
    a_async_latch: assert property (p_async_latch) else $error("async address not taken");

    property p_strobe_high;
        @(posedge clk_sys) disable iff (!rst_b)
        (st_r.stb.avd_n && !hrst && !(st_r.mode == MBF_BURST && bclk_rise))
            |=> $stable(st_r.addr);
    endproperty
    a_strobe_high: assert property (p_strobe_high) else $error("address taken with strobe high");

    property p_hw_reset;
        @(posedge clk_sys) disable iff (!rst_b)
        hrst |=> (st_r.mode == MBF_IDLE) && !st_r.first && (st_r.addr == ADDR_RST) ##1 !ready;
    endproperty
    a_hw_reset: assert property (p_hw_reset) else $error("hardware reset did not abort");

    property p_wp_top;
        @(posedge clk_sys) disable iff (!rst_b)
        (prog_try && !st_r.stb.wp_n && in_top(st_r.addr)) |-> !wr_en ##1 status.prog_refused;
    endproperty
    a_wp_top: assert property (p_wp_top) else $error("protected sector programmed");

    property p_accel;
        @(posedge clk_sys) disable iff (!rst_b)
        (st_r.stb.vpp_hh && wr_en) |=> status.unlock_bypass && status.prog_fast;
    endproperty
    a_accel: assert property (p_accel) else $error("accelerated program not flagged");

    property p_lockout;
        @(posedge clk_sys) disable iff (!rst_b)
        (prog_try && !st_r.stb.vpp_ih) |-> !wr_en ##1 (status.prog_refused && !status.prog_done);
    endproperty
    a_lockout: assert property (p_lockout) else $error("program passed supply lockout");

    property p_test_idle;
        @(posedge clk_sys) disable iff (!rst_b)
        !st_r.stb.tst |=> !status.test_active;
    endproperty
    a_test_idle: assert property (p_test_idle) else $error("test function active with pin low");

    property p_ce_sync;
        @(posedge clk_sys) disable iff (!rst_b)
        $rose(chip_sel_n) ##1 chip_sel_n [*3] |-> ##1 !muxed_addr_data_bus_oe && !ready;
    endproperty
    a_ce_sync: assert property (p_ce_sync) else $error("bus still driven after deselect");

    property p_ready;
        @(posedge clk_sys) disable iff (!rst_b)
        ready |-> st_r.mode == MBF_BURST && st_r.first && rd_data == u_array.mem[st_r.addr[MEM_AW-1:0]];
    endproperty
    a_ready: assert property (p_ready) else $error("ready without valid burst data");

    property p_wrap;
        @(posedge clk_sys) disable iff (!rst_b)
        (st_r.mode == MBF_BURST && st_r.first && bclk_rise && st_r.stb.avd_n && !hrst
         && cfg.wrap_en && cfg.blen == MBF_LEN_8)
            |=> st_r.addr[ADDR_W-1:3] == $past(st_r.addr[ADDR_W-1:3]);
    endproperty
    a_wrap: assert property (p_wrap) else $error("burst left its aligned group");

endmodule : mbf_ctrl

// ### mbf_host_model.sv
/*
 * Host controller model for the muxed burst flash pins: address latch,
 * burst clocking, asynchronous read and word program, offered as tasks.
 * Assumes: the bench resolves the bus wire and calls tasks just after a clock edge.
 */
`timescale 1ns/10ps
module mbf_host_model (
    // Clock
    input wire logic clk_sys,
    // Host strobes and burst clock
    output logic burst_clk,
    output logic address_valid_strobe_n,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_en_n,
    // Address and bus
    output logic [mbf_pkg::UP_W-1:0] addr_upper,
    output logic [mbf_pkg::DATA_W-1:0] host_bus
);
    import mbf_pkg::*;
    // ************************************************************
    // Pin driving
    // ************************************************************
    logic drive_r = 1'b0;
    logic [DATA_W-1:0] val_r = 16'h0000;
    logic [DATA_W-1:0] junk_r = 16'h5A5A;
    // Released bus shows a changing pattern so no stale address looks valid
    always @(posedge clk_sys) begin
        junk_r <= {junk_r[14:0], ~junk_r[15]};
    end
    assign host_bus = drive_r ? val_r : junk_r;
    // Idle pin levels at time zero
    initial begin
        burst_clk = 1'b0;
        address_valid_strobe_n = 1'b1;
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        write_en_n = 1'b1;
        addr_upper = 9'h000;
    end
    // Every level is held past the three-flop filter
    task automatic hold();
        repeat (6) @(posedge clk_sys);
    endtask : hold
    // Address phase; burst clock only rises for a burst latch
    task automatic latch(input logic [ADDR_W-1:0] a, input logic burst);
        chip_sel_n <= 1'b0;
        address_valid_strobe_n <= 1'b0;
        addr_upper <= a[ADDR_W-1:DATA_W];
        val_r <= a[DATA_W-1:0];
        drive_r <= 1'b1;
        hold();
        if (burst) begin
            burst_clk <= 1'b1;
            hold();
            burst_clk <= 1'b0;
        end
        address_valid_strobe_n <= 1'b1;
        drive_r <= 1'b0;
        hold();
    endtask : latch
    // One burst clock period
    task automatic clock_word();
        burst_clk <= 1'b1;
        hold();
        burst_clk <= 1'b0;
        hold();
    endtask : clock_word
    task automatic read_on();
        out_en_n <= 1'b0;
        hold();
    endtask : read_on
    task automatic finish_access();
        out_en_n <= 1'b1;
        chip_sel_n <= 1'b1;
        hold();
    endtask : finish_access
    // Word program; burst clock stays low through this async access
    task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        latch(a, 1'b0);
        val_r <= d;
        drive_r <= 1'b1;
        write_en_n <= 1'b0;
        hold();
        write_en_n <= 1'b1;
        hold();
        drive_r <= 1'b0;
        chip_sel_n <= 1'b1;
        hold();
    endtask : write_word
endmodule : mbf_host_model

// ### mbf_pkg.sv
/*
 * Shared constants, enumerations and carrier structs for the muxed burst
 * flash pin control block.
 * Assumes: one system clock; all pins arrive from outside that clock domain.
 */
package mbf_pkg;

    // ****************************************************************
    // Widths and address layout
    // ****************************************************************
    localparam int DATA_W = 16;               // Muxed low address / data
    localparam int UP_W = 9;                  // Address-only upper bits
    localparam int ADDR_W = DATA_W + UP_W;    // Full word address
    localparam int SECT_LSB = 16;             // Sector index starts here
    localparam int SECT_W = ADDR_W - SECT_LSB;
    localparam logic [SECT_W-1:0] TOP_SECT_MIN = 9'h1FC; // First of four top sectors
    localparam logic [ADDR_W-1:0] ADDR_RST = 25'h0000000;

    // ****************************************************************
    // Modes and burst configuration
    // ****************************************************************
    typedef enum logic [1:0] {
        MBF_IDLE  = 2'b00,
        MBF_ASYNC = 2'b01,
        MBF_BURST = 2'b10
    } mbf_mode_t;

    typedef enum logic [1:0] {
        MBF_LEN_CONT = 2'b00,
        MBF_LEN_8    = 2'b01,
        MBF_LEN_16   = 2'b10,
        MBF_LEN_32   = 2'b11
    } mbf_blen_t;

    typedef struct packed {
        mbf_blen_t blen;
        logic wrap_en;
    } mbf_cfg_t;

    // ****************************************************************
    // Pin group, sampled as one word through the synchroniser
    // ****************************************************************
    typedef struct packed {
        logic bclk;
        logic avd_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic hrst_n;
        logic wp_n;
        logic vpp_ih;
        logic vpp_hh;
        logic tst;
        logic [UP_W-1:0] up;
        logic [DATA_W-1:0] bus;
    } mbf_pins_t;

    typedef struct packed {
        logic unlock_bypass;
        logic test_active;
        logic prog_done;
        logic prog_refused;
        logic prog_fast;
    } mbf_status_t;

    typedef struct packed {
        mbf_pins_t s1;
        mbf_pins_t s2;
        mbf_pins_t s3;
        mbf_pins_t stb;
        mbf_mode_t mode;
        logic [ADDR_W-1:0] addr;
        logic first;
        logic ready;
        logic drive;
        mbf_status_t stat;
    } mbf_state_t;

endpackage : mbf_pkg

// ### test_muxed_burst_flash_pin_control.sv
/*
 * Self-checking bench for the muxed burst flash pin control.
 * Assumes: host model drives strobes; 64-word array so wrap groups differ.
 */
`timescale 1ns/10ps
module test_muxed_burst_flash_pin_control;
    import mbf_pkg::*;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic hw_reset_n = 1'b1;
    logic write_protect_n = 1'b1;
    logic vpp_ok = 1'b1;
    logic vpp_hh = 1'b0;
    logic test_pin = 1'b0;
    mbf_cfg_t cfg = '{blen: MBF_LEN_8, wrap_en: 1'b1};
    logic bclk, avd_n, ce_n, oe_n, we_n, doe, rdy;
    logic [UP_W-1:0] up;
    logic [DATA_W-1:0] host_bus, bus_wire, dout;
    mbf_status_t status;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_done = 0;
    int n_refused = 0;
    int n_fast = 0;
    always #25 clk_sys = ~clk_sys;
    // Bus wire: the block wins while it drives
    assign bus_wire = doe ? dout : host_bus;
    mbf_host_model host_u (.clk_sys(clk_sys), .burst_clk(bclk), .address_valid_strobe_n(avd_n),
        .chip_sel_n(ce_n), .out_en_n(oe_n), .write_en_n(we_n), .addr_upper(up), .host_bus(host_bus));
    mbf_ctrl #(.MEM_AW(6)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .burst_clk(bclk),
        .address_valid_strobe_n(avd_n), .chip_sel_n(ce_n), .out_en_n(oe_n), .write_en_n(we_n),
        .hw_reset_n(hw_reset_n), .write_protect_n(write_protect_n), .vpp_above_logic_low_level(vpp_ok),
        .vpp_at_high_voltage_level(vpp_hh), .vendor_test_pin(test_pin), .addr_upper(up),
        .muxed_addr_data_bus_in(bus_wire), .muxed_addr_data_bus_out(dout),
        .muxed_addr_data_bus_oe(doe), .ready(rdy), .cfg(cfg), .status(status));
    // Status pulses last one cycle, so count them as they pass
    always @(posedge clk_sys) begin
        if (status.prog_done === 1'b1) n_done++;
        if (status.prog_refused === 1'b1) n_refused++;
        if (status.prog_fast === 1'b1) n_fast++;
    end
    // ************************************************************
    // Compare and close
    // ************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // ************************************************************
    // Scenarios
    // ************************************************************
    // Four burst words; expected address from group size and wrap choice
    task automatic t_burst(input mbf_blen_t bl, input logic wr, input logic [5:0] start);
        logic [5:0] mask;
        logic [5:0] a;
        case (bl)
            MBF_LEN_8: mask = 6'h07;
            MBF_LEN_16: mask = 6'h0F;
            MBF_LEN_32: mask = 6'h1F;
            default: mask = 6'h3F;
        endcase
        if (!wr) mask = 6'h3F;
        cfg <= '{blen: bl, wrap_en: wr};
        host_u.latch({19'h00000, start}, 1'b1);
        check("ready before word", 16'(rdy), 16'h0000);
        host_u.read_on();
        for (int i = 0; i < 4; i++) begin
            host_u.clock_word();
            a = (start & ~mask) | ((start + 6'(i)) & mask);
            check("burst ready", 16'(rdy), 16'h0001);
            check("burst word", dout, 16'hC100 + 16'(a));
        end
        host_u.finish_access();
    endtask : t_burst
    // One program attempt under given protect and supply levels
    task automatic t_prog(input logic wp, input logic ok, input logic hh, input logic [8:0] ua,
                          input logic [5:0] idx, input logic done_exp);
        int d0;
        int r0;
        int f0;
        d0 = n_done;
        r0 = n_refused;
        f0 = n_fast;
        write_protect_n <= wp;
        vpp_ok <= ok;
        vpp_hh <= hh;
        repeat (6) @(posedge clk_sys);
        check("unlock bypass", 16'(status.unlock_bypass), 16'(hh));
        host_u.write_word({ua, 10'h000, idx}, 16'h0BAD);
        check("prog done", 16'(n_done - d0), 16'(done_exp));
        check("prog refused", 16'(n_refused - r0), 16'(!done_exp));
        check("prog fast", 16'(n_fast - f0), 16'(hh));
    endtask : t_prog
    // Strobe high while the released bus wanders must not move the address
    task automatic t_async(input logic [5:0] idx, input logic [15:0] exp);
        host_u.latch({19'h00000, idx}, 1'b0);
        host_u.read_on();
        check("async drive", 16'(doe), 16'h0001);
        check("async word", dout, exp);
        host_u.finish_access();
    endtask : t_async
    // Hardware reset in mid-burst, then a clock with no fresh latch
    task automatic t_hw_reset();
        host_u.latch(25'h0000010, 1'b1);
        host_u.read_on();
        host_u.clock_word();
        check("ready in burst", 16'(rdy), 16'h0001);
        hw_reset_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check("ready on reset", 16'(rdy), 16'h0000);
        hw_reset_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        host_u.clock_word();
        check("ready without latch", 16'(rdy), 16'h0000);
        host_u.finish_access();
    endtask : t_hw_reset
    task automatic t_test_pin(input logic lvl);
        test_pin <= lvl;
        repeat (6) @(posedge clk_sys);
        check("test active", 16'(status.test_active), 16'(lvl));
    endtask : t_test_pin
    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (19) @(posedge clk_sys);
        check("reset data", dout, 16'h0000);
        check("reset flags", 16'({doe, rdy, status}), 16'h0000);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk_sys);
        for (int i = 0; i < 64; i++) host_u.write_word({19'h00000, 6'(i)}, 16'hC100 + 16'(i));
        check("fill writes", 16'(n_done), 16'h0040);
        t_burst(MBF_LEN_8, 1'b1, 6'h06);
        t_burst(MBF_LEN_8, 1'b0, 6'h06);
        t_burst(MBF_LEN_16, 1'b1, 6'h0E);
        t_burst(MBF_LEN_32, 1'b1, 6'h1E);
        t_burst(MBF_LEN_CONT, 1'b1, 6'h1E);
        t_prog(1'b1, 1'b0, 1'b0, 9'h000, 6'h05, 1'b0);
        t_prog(1'b1, 1'b1, 1'b1, 9'h000, 6'h06, 1'b1);
        t_prog(1'b0, 1'b1, 1'b0, 9'h1FC, 6'h05, 1'b0);
        t_prog(1'b0, 1'b1, 1'b0, 9'h1FB, 6'h06, 1'b1);
        t_async(6'h05, 16'hC105);
        t_async(6'h06, 16'h0BAD);
        t_hw_reset();
        t_burst(MBF_LEN_8, 1'b1, 6'h09);
        t_test_pin(1'b0);
        t_test_pin(1'b1);
        t_test_pin(1'b0);
        conclude();
    end
    // A hang counts as a mismatch
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        conclude();
    end
endmodule : test_muxed_burst_flash_pin_control
